// ===== rtl/tst_edge_sync.sv
// Two-flop synchroniser with edge detection for the test clock
`timescale 1ns/100ps
module tst_edge_sync (
  // System
  input  wire logic clk_sys,
  input  wire logic srst,
  // Pin
  input  wire logic pinIn,
  // Result
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      last_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;
endmodule : tst_edge_sync

// ===== rtl/tst_pkg.sv
// Types for the scan test access port
package tst_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PAUDR, EX2DR, UPDDR,
    SELIR, CAPIR, SHIR, EX1IR, PAUIR, EX2IR, UPDIR
  } tst_state_t;
endpackage : tst_pkg

// ===== rtl/tst_tap.sv
// Test access port state controller, instruction, bypass and data scan registers
// Notes on behaviour
// - All test state changes only on a detected test clock edge.
// - Data input and mode select are sampled on the test clock rising edge.
// - Test data output and parallel outputs change only on falling edges.
// - Leaving Capture-IR loads instruction shift register with 10000001.
// - Output driver enables on the falling edge after entering a shift state.
// - One bit shifts per rising edge; last bit shifts entering Exit1.
// - Output driver releases on the falling edge in Exit1-IR or Exit1-DR.
// - Shifted instruction moves to active latch on falling edge in Update-IR.
// - All-ones instruction selects the bypass stage.
// - Bypass stage loads zero when leaving Capture-DR.
// - Selected data register parallel output updates on falling edge in Update-DR.
`timescale 1ns/100ps
`include "tst_tap_regs.svh"
module tst_tap (
  // System
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  // Test pins
  input  wire logic                     tck,
  input  wire logic                     tms,
  input  wire logic                     tdi,
  output logic                          tdoOut,
  output logic                          tdoOe,
  // Normal-function pins
  input  wire logic [`TST_DR_WIDTH-1:0] funcIn,
  output logic [`TST_DR_WIDTH-1:0]      funcOut,
  // Status
  output logic [`TST_IR_WIDTH-1:0]      activeIr,
  output logic                          bypassSel,
  output tst_pkg::tst_state_t           tapState
);
  logic tckRise, tckFall;
  logic tmsS, tdiS;
  logic [`TST_DR_WIDTH-1:0] funcS;
  logic [`TST_DR_WIDTH-1:0] funcM_q;

  tst_edge_sync u_tck (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pinIn   (tck),
    .level   (),
    .rise    (tckRise),
    .fall    (tckFall)
  );

  // ==========================================================
  // Pin synchronisers, delay aligned with the clock edge detect
  logic [1:0]               tmsP_q, tmsP_d;
  logic [1:0]               tdiP_q, tdiP_d;
  logic [`TST_DR_WIDTH-1:0] funcM_d, funcP_q, funcP_d;

  always_comb begin
    tmsP_d  = {tmsP_q[0], tms};
    tdiP_d  = {tdiP_q[0], tdi};
    funcM_d = funcIn;
    funcP_d = funcM_q;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tmsP_q  <= 2'h3;
      tdiP_q  <= 2'h0;
      funcM_q <= '0;
      funcP_q <= '0;
    end else begin
      tmsP_q  <= tmsP_d;
      tdiP_q  <= tdiP_d;
      funcM_q <= funcM_d;
      funcP_q <= funcP_d;
    end
  end
  assign tmsS  = tmsP_q[1];
  assign tdiS  = tdiP_q[1];
  assign funcS = funcP_q;

  // ==========================================================
  // Next-state function of the controller
  function automatic tst_pkg::tst_state_t nextState(input tst_pkg::tst_state_t s,
                                                     input logic m);
    case (s)
      tst_pkg::TLR:   nextState = m ? tst_pkg::TLR   : tst_pkg::RTI;
      tst_pkg::RTI:   nextState = m ? tst_pkg::SELDR : tst_pkg::RTI;
      tst_pkg::SELDR: nextState = m ? tst_pkg::SELIR : tst_pkg::CAPDR;
      tst_pkg::CAPDR: nextState = m ? tst_pkg::EX1DR : tst_pkg::SHDR;
      tst_pkg::SHDR:  nextState = m ? tst_pkg::EX1DR : tst_pkg::SHDR;
      tst_pkg::EX1DR: nextState = m ? tst_pkg::UPDDR : tst_pkg::PAUDR;
      tst_pkg::PAUDR: nextState = m ? tst_pkg::EX2DR : tst_pkg::PAUDR;
      tst_pkg::EX2DR: nextState = m ? tst_pkg::UPDDR : tst_pkg::SHDR;
      tst_pkg::UPDDR: nextState = m ? tst_pkg::SELDR : tst_pkg::RTI;
      tst_pkg::SELIR: nextState = m ? tst_pkg::TLR   : tst_pkg::CAPIR;
      tst_pkg::CAPIR: nextState = m ? tst_pkg::EX1IR : tst_pkg::SHIR;
      tst_pkg::SHIR:  nextState = m ? tst_pkg::EX1IR : tst_pkg::SHIR;
      tst_pkg::EX1IR: nextState = m ? tst_pkg::UPDIR : tst_pkg::PAUIR;
      tst_pkg::PAUIR: nextState = m ? tst_pkg::EX2IR : tst_pkg::PAUIR;
      tst_pkg::EX2IR: nextState = m ? tst_pkg::UPDIR : tst_pkg::SHIR;
      tst_pkg::UPDIR: nextState = m ? tst_pkg::SELDR : tst_pkg::RTI;
      default:        nextState = tst_pkg::TLR;
    endcase
  endfunction : nextState

  // ==========================================================
  // State and scan registers
  tst_pkg::tst_state_t      state_q, state_d;
  logic [`TST_IR_WIDTH-1:0] irShift_q, irShift_d;
  logic [`TST_IR_WIDTH-1:0] irLatch_q, irLatch_d;
  logic                     bypass_q, bypass_d;
  logic [`TST_DR_WIDTH-1:0] drShift_q, drShift_d;
  logic [`TST_DR_WIDTH-1:0] drOut_q, drOut_d;
  logic                     tdo_q, tdo_d;
  logic                     oe_q, oe_d;
  logic                     isBypass;

  assign isBypass = (irLatch_q == `TST_IR_BYPASS);

  // ==========================================================
  // State controller, stepped on each detected rising edge
  always_comb begin
    state_d = state_q;
    if (tckRise) begin
      state_d = nextState(state_q, tmsS);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= tst_pkg::TLR;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Scan registers and serial output
  always_comb begin
    irShift_d = irShift_q;
    irLatch_d = irLatch_q;
    bypass_d  = bypass_q;
    drShift_d = drShift_q;
    drOut_d   = drOut_q;
    tdo_d     = tdo_q;
    oe_d      = oe_q;
    if (tckRise) begin
      case (state_q)
        tst_pkg::CAPIR: irShift_d = `TST_IR_CAPTURE;
        tst_pkg::SHIR:  irShift_d = {tdiS, irShift_q[`TST_IR_WIDTH-1:1]};
        tst_pkg::CAPDR: begin
          if (isBypass) begin
            bypass_d = 1'h0;
          end else begin
            drShift_d = funcS;
          end
        end
        tst_pkg::SHDR: begin
          if (isBypass) begin
            bypass_d = tdiS;
          end else begin
            drShift_d = {tdiS, drShift_q[`TST_DR_WIDTH-1:1]};
          end
        end
        default: begin
        end
      endcase
    end else if (tckFall) begin
      case (state_q)
        tst_pkg::SHIR: begin
          oe_d  = 1'h1;
          tdo_d = irShift_q[0];
        end
        tst_pkg::SHDR: begin
          oe_d  = 1'h1;
          tdo_d = isBypass ? bypass_q : drShift_q[0];
        end
        tst_pkg::EX1IR, tst_pkg::EX1DR: oe_d = 1'h0;
        tst_pkg::UPDIR: irLatch_d = irShift_q;
        tst_pkg::UPDDR: begin
          if (!isBypass) begin
            drOut_d = drShift_q;
          end
        end
        tst_pkg::TLR: begin
          oe_d      = 1'h0;
          irLatch_d = `TST_IR_RESET;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irShift_q <= `TST_IR_CAPTURE;
      irLatch_q <= `TST_IR_RESET;
      bypass_q  <= 1'h0;
      drShift_q <= `TST_DR_RESET;
      drOut_q   <= `TST_DR_RESET;
      tdo_q     <= 1'h0;
      oe_q      <= 1'h0;
    end else begin
      irShift_q <= irShift_d;
      irLatch_q <= irLatch_d;
      bypass_q  <= bypass_d;
      drShift_q <= drShift_d;
      drOut_q   <= drOut_d;
      tdo_q     <= tdo_d;
      oe_q      <= oe_d;
    end
  end

  // ==========================================================
  // Outputs
  assign tdoOut    = tdo_q;
  assign tdoOe     = oe_q;
  assign funcOut   = drOut_q;
  assign activeIr  = irLatch_q;
  assign bypassSel = isBypass;
  assign tapState  = state_q;
endmodule : tst_tap

// ===== rtl/tst_tap_regs.svh
// Constants for the scan test access port
`ifndef TST_TAP_REGS_SVH
`define TST_TAP_REGS_SVH
`define TST_IR_WIDTH      8
`define TST_IR_CAPTURE    8'h81
`define TST_IR_BYPASS     8'hff
`define TST_IR_RESET      8'hff
`define TST_DR_WIDTH      8
`define TST_DR_RESET      8'h00
`endif

// ===== tb/tb.sv
// Testbench for the scan test access port
`timescale 1ns/100ps
`include "tst_tap_regs.svh"
`define CHK(a, x) begin checked++; if ((a) !== (x)) begin fail_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, x); end end
module tb;
  logic clk_sys, srst, tck, tms, tdi, tdoOut, tdoOe, bypassSel, e;
  logic [7:0] funcIn, funcOut, activeIr, ins, fo;
  tst_pkg::tst_state_t tapState;
  int fail_count, checked;
  logic expQ[$];
  localparam logic [7:0] IRCAP = `TST_IR_CAPTURE;
  tst_tap dut_u (.clk_sys(clk_sys), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdoOut(tdoOut), .tdoOe(tdoOe), .funcIn(funcIn), .funcOut(funcOut),
    .activeIr(activeIr), .bypassSel(bypassSel), .tapState(tapState));
  tst_ctl_model ctl_u (.tck(tck), .tms(tms), .tdi(tdi));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Serial output monitor, sampled at each test clock fall
  always @(negedge tck) if (tdoOe === 1'b1) begin
    e = (expQ.size() == 0) ? 1'hx : expQ.pop_front();
    `CHK(tdoOut, e)
  end
  task automatic results;
    $display("Checks %0d, failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic irScan(input logic [7:0] v);
    for (int i = 0; i < 8; i++) expQ.push_back(IRCAP[i]);
    ctl_u.scan(1'h1, v);
    `CHK(activeIr, v)
    `CHK(expQ.size(), 0)
    `CHK(tdoOe, 1'h0)
    `CHK(bypassSel, v == 8'hff)
  endtask : irScan
  task automatic drScan(input logic [7:0] v);
    logic [8:0] sh;
    sh = {v, 1'h0};
    for (int i = 0; i < 8; i++) expQ.push_back((ins == 8'hff) ? sh[i] : funcIn[i]);
    ctl_u.scan(1'h0, v);
    if (ins != 8'hff) fo = v;
    `CHK(funcOut, fo)
    `CHK(expQ.size(), 0)
    `CHK(tdoOe, 1'h0)
  endtask : drScan
  initial begin
    srst = 1'h1;
    funcIn = 8'h00;
    fo = 8'h00;
    void'($urandom(32'hf649944f));
    repeat (2) @(posedge clk_sys);
    #1 srst = 1'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(tapState, tst_pkg::TLR)
    ctl_u.cyc(1'h0, 1'h0);
    for (int k = 0; k < 6; k++) begin
      ins = (k % 2 == 0) ? 8'hff : 8'($urandom);
      funcIn = 8'($urandom);
      irScan(ins);
      drScan(8'($urandom));
    end
    repeat (5) ctl_u.cyc(1'h1, 1'h0);
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK(tapState, tst_pkg::TLR)
    `CHK(activeIr, 8'hff)
    results();
  end
  initial begin
    #100000;
    fail_count++;
    $display("[FAIL] %0t timeout", $time);
    results();
  end
endmodule : tb
bind tst_tap tst_tap_sva chk_u (.clk_sys(clk_sys), .srst(srst), .tck(tck), .tdoOut(tdoOut),
  .tdoOe(tdoOe), .funcOut(funcOut), .activeIr(activeIr), .bypassSel(bypassSel),
  .tapState(tapState));

// ===== tb/tst_ctl_model.sv
// Test controller model driving the scan pins
`timescale 1ns/100ps
module tst_ctl_model (
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // One test clock cycle; pins change at the fall, clock stands low after
  task automatic cyc(input logic m, input logic d);
    tms = m;
    tdi = d;
    #80 tck = 1'h1;
    #80 tck = 1'h0;
  endtask : cyc
  // Scan from Run-Test/Idle back to Run-Test/Idle; idle data toggles
  task automatic scan(input logic ir, input logic [7:0] d);
    cyc(1'h1, ~tdi);
    if (ir) cyc(1'h1, ~tdi);
    cyc(1'h0, ~tdi);
    cyc(1'h0, ~tdi);
    for (int i = 0; i < 8; i++) cyc(i == 7, d[i]);
    cyc(1'h1, ~tdi);
    cyc(1'h0, ~tdi);
  endtask : scan
endmodule : tst_ctl_model

// ===== tb/tst_tap_sva.sv
// Port checker for the scan test access port
`timescale 1ns/100ps
module tst_tap_sva (
  // System
  input wire logic       clk_sys,
  input wire logic       srst,
  // Pins
  input wire logic       tck,
  input wire logic       tdoOut,
  input wire logic       tdoOe,
  // Status
  input wire logic [7:0] funcOut,
  input wire logic [7:0] activeIr,
  input wire logic       bypassSel,
  input tst_pkg::tst_state_t tapState
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  state_on_rise_a: assert property ($changed(tapState) |-> $past(tck, 2))
    else $error("state moved off a test clock rise");
  tdo_on_fall_a: assert property (
    ($changed(tdoOut) || $changed(tdoOe)) |-> !$past(tck, 2))
    else $error("output moved off a test clock fall");
  oe_in_shift_a: assert property (
    $rose(tdoOe) |-> tapState inside {tst_pkg::SHIR, tst_pkg::SHDR})
    else $error("driver enabled outside shift");
  oe_release_a: assert property (
    $fell(tdoOe) |-> tapState inside {tst_pkg::EX1IR, tst_pkg::EX1DR, tst_pkg::TLR})
    else $error("driver released outside exit");
  ir_update_a: assert property (
    $changed(activeIr) |-> tapState inside {tst_pkg::UPDIR, tst_pkg::TLR})
    else $error("instruction changed outside update");
  dr_update_a: assert property ($changed(funcOut) |-> tapState == tst_pkg::UPDDR)
    else $error("parallel output changed outside update");
  bypass_decode_a: assert property (bypassSel == (activeIr == 8'hff))
    else $error("bypass decode wrong");
  ir_capture_a: assert property ($rose(tdoOe) && tapState == tst_pkg::SHIR |-> tdoOut)
    else $error("instruction capture bit wrong");
  bypass_zero_a: assert property (
    $rose(tdoOe) && tapState == tst_pkg::SHDR && bypassSel |-> !tdoOut)
    else $error("bypass capture not zero");
  cover property ($rose(tdoOe) && tapState == tst_pkg::SHDR && bypassSel);
  cover property ($changed(activeIr) && tapState == tst_pkg::UPDIR);
  cover property ($changed(funcOut));
endmodule : tst_tap_sva
